// ### raster_setup_discard_bbox_tb.sv
`timescale 1ns/1ps
`default_nettype none
module raster_setup_discard_bbox_tb;
	import rsdb_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, irq, rerr, prim_valid, prim_ready, prim_use_shader_bounds, sb_valid;
	logic [15:0] win_width = 16'h0010, win_height = 16'h0010, prim_point_size, frag_x, frag_y;
	logic [15:0] sb_min_x, sb_min_y, sb_min_z, sb_min_w, sb_max_x, sb_max_y, sb_max_z, sb_max_w;
	logic [15:0] xmn, ymn, xmx, ymx, ms = 16'h0;
	logic [1:0] prim_type, mt = 2'h0;
	logic win_present = 1'b1, clear_req = 1'b0, per_buffer_clear_req = 1'b0, frag_ready = 1'b0;
	logic clear_go, per_buffer_clear_go, frag_valid, go = 1'b0, mu = 1'b0, sgo = 1'b0;
	int err_total = 0, checks_done = 0, cyc = 0, fcnt = 0, cgo = 0, pgo = 0;
	always #20 pclk = ~pclk;
	rsdb_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .win_width, .win_height, .win_present, .prim_valid, .prim_ready, .prim_type,
		.prim_point_size, .prim_use_shader_bounds, .sb_valid, .sb_min_x, .sb_min_y, .sb_min_z,
		.sb_min_w, .sb_max_x, .sb_max_y, .sb_max_z, .sb_max_w, .clear_req, .per_buffer_clear_req,
		.clear_go, .per_buffer_clear_go, .frag_valid, .frag_ready, .frag_x, .frag_y);
	rsdb_prim_src u_src (.pclk, .presetn, .go, .typ(mt), .psz(ms), .use_sb(mu), .gap({mu, mu}),
		.sb_go(sgo), .prim_valid, .prim_ready, .prim_type, .prim_point_size,
		.prim_use_shader_bounds, .sb_valid, .sb_min_x, .sb_min_y, .sb_min_z, .sb_min_w,
		.sb_max_x, .sb_max_y, .sb_max_z, .sb_max_w);
	// sink stalls every other cycle
	always @(posedge pclk) begin
		if (frag_valid && frag_ready) begin
			fcnt++;
			xmn = (frag_x < xmn) ? frag_x : xmn;
			ymn = (frag_y < ymn) ? frag_y : ymn;
			xmx = (frag_x > xmx) ? frag_x : xmx;
			ymx = (frag_y > ymx) ? frag_y : ymx;
		end
		cgo += clear_go;
		pgo += per_buffer_clear_go;
		frag_ready <= ~frag_ready;
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no fixed wait count; only the cycle ceiling ends a hang
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic t_prim(input logic [1:0] ty, input logic [15:0] ps, input logic sb, input int n,
		input logic [15:0] x0, input logic [15:0] y0, input logic [15:0] x1, input logic [15:0] y1);
		fcnt = 0;
		xmn = 16'hFFFF;
		ymn = 16'hFFFF;
		xmx = 16'h0000;
		ymx = 16'h0000;
		sgo <= sb;
		mt <= ty;
		ms <= ps;
		mu <= sb;
		@(posedge pclk);
		sgo <= 1'b0;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (8) @(posedge pclk);
		while (prim_ready !== 1'b1) begin
			@(posedge pclk);
		end
		repeat (2) @(posedge pclk);
		chk(fcnt, n);
		if (n > 0) begin
			chk({xmn, ymn}, {x0, y0});
			chk({xmx, ymx}, {x1, y1});
		end
	endtask
	task automatic t_reset_state();
		win_present <= 1'b0;
		do_reset();
		rc(ADDR_VP_W, 32'h0);
		rc(ADDR_VP_H, 32'h0);
		win_present <= 1'b1;
		do_reset();
		rc(ADDR_VP_W, 32'h10);
		rc(ADDR_VP_X, 32'h0);
		rc(ADDR_DEPTH_NEAR, 32'h0);
		rc(ADDR_DEPTH_FAR, 32'h10000);
		rc(ADDR_CTRL, 32'h0);
		$display("test reset_state done");
	endtask
	task automatic t_regs();
		apb(1'b1, ADDR_VP_W, 32'h80000004);
		rc(ADDR_VP_W, 32'h10);
		rc(ADDR_STATUS, 32'h1);
		apb(1'b1, ADDR_MASK, 32'h1);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b1, ADDR_MASK, 32'h0);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, ADDR_STATUS, 32'hF);
		rc(ADDR_STATUS, 32'h0);
		rc(8'hFC, 32'h0);
		chk(rerr, 1'b1);
		apb(1'b1, ADDR_DEPTH_NEAR, 32'h20000);
		rc(ADDR_DEPTH_NEAR, 32'h10000);
		apb(1'b1, ADDR_DEPTH_FAR, 32'h4000);
		rc(ADDR_DEPTH_FAR, 32'h4000);
		$display("test regs done");
	endtask
	task automatic t_raster();
		apb(1'b1, ADDR_VP_X, 32'h2);
		apb(1'b1, ADDR_VP_Y, 32'h2);
		apb(1'b1, ADDR_VP_W, 32'h4);
		apb(1'b1, ADDR_VP_H, 32'h4);
		apb(1'b1, ADDR_BB_MIN_ZW, 32'h0100FF00);
		apb(1'b1, ADDR_BB_MAX_ZW, 32'h01000100);
		t_prim(PRIM_TRI, 16'h0, 1'b0, 16, 16'h2, 16'h2, 16'h5, 16'h5);
		rc(ADDR_RES_X, 32'h00060002);
		rc(ADDR_RES_ZMIN, 32'h00004000);
		rc(ADDR_RES_ZMAX, 32'h00010000);
		t_prim(PRIM_POINT, 16'h0180, 1'b0, 36, 16'h1, 16'h1, 16'h6, 16'h6);
		apb(1'b1, ADDR_LINE_WIDTH, 32'h02A0);
		t_prim(PRIM_LINE, 16'h0, 1'b0, 64, 16'h0, 16'h0, 16'h7, 16'h7);
		t_prim(PRIM_TRI, 16'h0, 1'b1, 4, 16'h3, 16'h3, 16'h4, 16'h4);
		apb(1'b1, ADDR_VP_X, 32'h3);
		t_prim(PRIM_TRI, 16'h0, 1'b0, 16, 16'h3, 16'h2, 16'h6, 16'h5);
		apb(1'b1, ADDR_VP_X, 32'hE);
		t_prim(PRIM_TRI, 16'h0, 1'b0, 8, 16'hE, 16'h2, 16'hF, 16'h5);
		// negative w corners: whole framebuffer is scanned
		apb(1'b1, ADDR_BB_MIN_ZW, 32'hFF00FF00);
		t_prim(PRIM_TRI, 16'h0, 1'b0, 256, 16'h0, 16'h0, 16'hF, 16'hF);
		apb(1'b1, ADDR_BB_MIN_ZW, 32'h0100FF00);
		$display("test raster done");
	endtask
	task automatic t_discard(input logic d);
		apb(1'b1, ADDR_STATUS, 32'hF);
		apb(1'b1, ADDR_CTRL, {31'h0, d});
		t_prim(PRIM_TRI, 16'h0, 1'b0, d ? 0 : 8, 16'hE, 16'h2, 16'hF, 16'h5);
		cgo = 0;
		pgo = 0;
		clear_req <= 1'b1;
		per_buffer_clear_req <= 1'b1;
		@(posedge pclk);
		clear_req <= 1'b0;
		per_buffer_clear_req <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({cgo[7:0], pgo[7:0]}, d ? 16'h0 : 16'h0101);
		rc(ADDR_STATUS, d ? 32'hA : 32'h4);
		$display("test discard done");
	endtask
	initial begin
		t_reset_state();
		t_regs();
		t_raster();
		t_discard(1'b1);
		t_discard(1'b0);
		complete_run();
	end
endmodule
bind rsdb_top rsdb_chk #(.DIM_W(DIM_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .win_width, .win_height, .prim_valid, .prim_ready, .clear_req,
	.per_buffer_clear_req, .clear_go, .per_buffer_clear_go, .frag_valid, .frag_ready, .frag_x,
	.frag_y);
`default_nettype wire

// ### rsdb_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rsdb_chk #(
	parameter int DIM_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rsdb_pkg::ADDR_W-1:0] paddr,
	input wire logic [rsdb_pkg::DATA_W-1:0] pwdata,
	input wire logic pready,
	input wire logic [DIM_W-1:0] win_width,
	input wire logic [DIM_W-1:0] win_height,
	input wire logic prim_valid,
	input wire logic prim_ready,
	input wire logic clear_req,
	input wire logic per_buffer_clear_req,
	input wire logic clear_go,
	input wire logic per_buffer_clear_go,
	input wire logic frag_valid,
	input wire logic frag_ready,
	input wire logic [DIM_W-1:0] frag_x,
	input wire logic [DIM_W-1:0] frag_y
);
	import rsdb_pkg::*;
	logic disc_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disc_q <= 1'b0;
		end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
			disc_q <= pwdata[CTRL_DISCARD_BIT];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_CLR_IGN: assert property (disc_q && clear_req |=> !clear_go)
		else $error("clear passed while discarding");
	AST_CLR_PASS: assert property (!disc_q && clear_req |=> clear_go)
		else $error("clear lost");
	AST_PBC_IGN: assert property (disc_q && per_buffer_clear_req |=> !per_buffer_clear_go)
		else $error("buffer clear passed while discarding");
	AST_PBC_PASS: assert property (!disc_q && per_buffer_clear_req |=> per_buffer_clear_go)
		else $error("buffer clear lost");
	AST_DROP: assert property (disc_q && prim_valid && prim_ready |=> !frag_valid [*4])
		else $error("fragment from dropped primitive");
	AST_DROP_RDY: assert property (disc_q && prim_valid && prim_ready |-> ##[1:3] prim_ready)
		else $error("ready slow after drop");
	AST_PASS: assert property (!disc_q && prim_valid && prim_ready
		|=> !prim_ready ##[1:19] (frag_valid || prim_ready))
		else $error("primitive not rasterized in time");
	AST_IN_FB: assert property (frag_valid |-> frag_x < win_width && frag_y < win_height)
		else $error("fragment outside framebuffer");
	AST_HOLD: assert property (frag_valid && !frag_ready
		|=> frag_valid && $stable(frag_x) && $stable(frag_y))
		else $error("fragment dropped while stalled");
endmodule
`default_nettype wire

// ### rsdb_pkg.sv
`default_nettype none
package rsdb_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK = 8'h08;
	localparam logic [7:0] ADDR_VP_X = 8'h0C;
	localparam logic [7:0] ADDR_VP_Y = 8'h10;
	localparam logic [7:0] ADDR_VP_W = 8'h14;
	localparam logic [7:0] ADDR_VP_H = 8'h18;
	localparam logic [7:0] ADDR_DEPTH_NEAR = 8'h1C;
	localparam logic [7:0] ADDR_DEPTH_FAR = 8'h20;
	localparam logic [7:0] ADDR_BB_MIN_XY = 8'h24;
	localparam logic [7:0] ADDR_BB_MIN_ZW = 8'h28;
	localparam logic [7:0] ADDR_BB_MAX_XY = 8'h2C;
	localparam logic [7:0] ADDR_BB_MAX_ZW = 8'h30;
	localparam logic [7:0] ADDR_POINT_MAX = 8'h34;
	localparam logic [7:0] ADDR_LINE_WIDTH = 8'h38;
	localparam logic [7:0] ADDR_LINE_MAX = 8'h3C;
	localparam logic [7:0] ADDR_RES_X = 8'h40;
	localparam logic [7:0] ADDR_RES_Y = 8'h44;
	localparam logic [7:0] ADDR_RES_ZMIN = 8'h48;
	localparam logic [7:0] ADDR_RES_ZMAX = 8'h4C;
	// control and status fields
	localparam int CTRL_DISCARD_BIT = 0;
	localparam int EVT_W = 4;
	localparam int EVT_VP_ERR = 0;
	localparam int EVT_PRIM_DROP = 1;
	localparam int EVT_PRIM_DONE = 2;
	localparam int EVT_CLEAR_IGN = 3;
	// fixed-point formats
	localparam int NDC_FRAC = 12;
	localparam int WIN_FRAC = 8;
	localparam logic [16:0] DEPTH_ONE = 17'h10000;
	localparam logic [16:0] DEPTH_ZERO = 17'h00000;
	localparam logic [15:0] SIZE_ONE = 16'h0100;
	localparam logic [15:0] SIZE_ROUND = 16'h0080;
	localparam logic [15:0] SIZE_INT_MASK = 16'hFF00;
	localparam logic [15:0] POINT_MAX_RST = 16'h4000;
	localparam logic [15:0] LINE_WIDTH_RST = 16'h0100;
	localparam logic [15:0] LINE_MAX_RST = 16'h0800;
	localparam logic [15:0] BB_MIN_RST = 16'hFF00;
	localparam logic [15:0] BB_MAX_RST = 16'h0100;
	localparam logic [3:0] CORNER_LAST = 4'hF;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CORNER = 3'b001,
		ST_EXPAND = 3'b010,
		ST_SCAN = 3'b011
	} rsdb_state_type;
	typedef enum logic [1:0] {
		PRIM_POINT = 2'b00,
		PRIM_LINE = 2'b01,
		PRIM_TRI = 2'b10
	} rsdb_prim_type;
endpackage
`default_nettype wire

// ### rsdb_prim_src.sv
`timescale 1ns/1ps
`default_nettype none
module rsdb_prim_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [1:0] typ,
	input wire logic [15:0] psz,
	input wire logic use_sb,
	input wire logic [1:0] gap,
	input wire logic sb_go,
	output logic prim_valid,
	input wire logic prim_ready,
	output logic [1:0] prim_type,
	output logic [15:0] prim_point_size,
	output logic prim_use_shader_bounds,
	output logic sb_valid,
	output logic [15:0] sb_min_x,
	output logic [15:0] sb_min_y,
	output logic [15:0] sb_min_z,
	output logic [15:0] sb_min_w,
	output logic [15:0] sb_max_x,
	output logic [15:0] sb_max_y,
	output logic [15:0] sb_max_z,
	output logic [15:0] sb_max_w
);
	logic [2:0] cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prim_valid <= 1'b0;
			cnt_q <= 3'h0;
		end else if (prim_valid && prim_ready) begin
			prim_valid <= 1'b0;
		end else if (go) begin
			cnt_q <= {1'b0, gap} + 3'h1;
		end else if (cnt_q == 3'h1) begin
			prim_valid <= 1'b1;
			cnt_q <= 3'h0;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end
	// idle payload toggles so stale values never look valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prim_type <= 2'h0;
			prim_point_size <= 16'h0000;
			prim_use_shader_bounds <= 1'b0;
		end else if (cnt_q == 3'h1) begin
			prim_type <= typ;
			prim_point_size <= psz;
			prim_use_shader_bounds <= use_sb;
		end else if (!prim_valid) begin
			prim_type <= ~prim_type;
			prim_point_size <= ~prim_point_size;
			prim_use_shader_bounds <= ~prim_use_shader_bounds;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sb_valid <= 1'b0;
		end else begin
			sb_valid <= sb_go;
		end
	end
	// box of -0.5..0.5 at w 1.0, inverted when not qualified
	assign sb_min_x = 16'hFF80 ^ {16{!sb_valid}};
	assign sb_min_y = 16'hFF80 ^ {16{!sb_valid}};
	assign sb_min_z = 16'hFF80 ^ {16{!sb_valid}};
	assign sb_min_w = 16'h0100 ^ {16{!sb_valid}};
	assign sb_max_x = 16'h0080 ^ {16{!sb_valid}};
	assign sb_max_y = 16'h0080 ^ {16{!sb_valid}};
	assign sb_max_z = 16'h0080 ^ {16{!sb_valid}};
	assign sb_max_w = 16'h0100 ^ {16{!sb_valid}};
endmodule
`default_nettype wire

// ### rsdb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - negative viewport width or height flags error, viewport left unchanged.
// - viewport state is x, y, width, height plus clamped near and far.
// - initial width and height come from window, zero when no window.
// - initial centre is half size; near starts 0.0, far 1.0.
// - fragment addressed by lower-left corner; centre is corner plus one half.
// - fragments outside the framebuffer are never emitted downstream.
// - discard enable drops primitives before rasterization, else they pass.
// - discard enable also ignores clear and per-buffer clear requests.
// - discard is one enable bit, reset to disabled.
// - bounds from command, or shader element zero min, element one max.
// - shader bounds apply to patch primitives, geometry outputs, clipped ones.
// - sixteen corners clipped at w>0, divided by w, viewport mapped.
// - window volume grown by half size in x,y, fragment aligned.
// - size is clamped point size, rounded clamped line width, zero triangles.
// - every covered fragment inside the volume is generated.
// - integer window translation shifts fragments exactly, nothing else.
// - near and far values clamped to the unit interval when written.
// - window x,y scale by half size plus centre; z by depth range.
module rsdb_top #(
	parameter int DIM_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rsdb_pkg::ADDR_W-1:0] paddr,
	input wire logic [rsdb_pkg::DATA_W-1:0] pwdata,
	output logic [rsdb_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic [DIM_W-1:0] win_width,
	input wire logic [DIM_W-1:0] win_height,
	input wire logic win_present,
	input wire logic prim_valid,
	output logic prim_ready,
	input wire logic [1:0] prim_type,
	input wire logic [15:0] prim_point_size,
	input wire logic prim_use_shader_bounds,
	input wire logic sb_valid,
	input wire logic [15:0] sb_min_x,
	input wire logic [15:0] sb_min_y,
	input wire logic [15:0] sb_min_z,
	input wire logic [15:0] sb_min_w,
	input wire logic [15:0] sb_max_x,
	input wire logic [15:0] sb_max_y,
	input wire logic [15:0] sb_max_z,
	input wire logic [15:0] sb_max_w,
	input wire logic clear_req,
	input wire logic per_buffer_clear_req,
	output logic clear_go,
	output logic per_buffer_clear_go,
	output logic frag_valid,
	input wire logic frag_ready,
	output logic [DIM_W-1:0] frag_x,
	output logic [DIM_W-1:0] frag_y
);
	import rsdb_pkg::*;

	if (DIM_W != 16) begin : g_bad_dim
		$error("rsdb_top: DIM_W must be 16");
	end

	rsdb_state_type state_q;
	logic discard_q;
	logic [EVT_W-1:0] status_q, mask_q, evt;
	logic init_q;
	logic signed [15:0] vp_x_q, vp_y_q;
	logic [15:0] vp_w_q, vp_h_q;
	logic [16:0] near_q, far_q;
	logic [15:0] cb_min_q [4];
	logic [15:0] cb_max_q [4];
	logic [15:0] sb_min_q [4];
	logic [15:0] sb_max_q [4];
	logic [15:0] point_max_q, line_width_q, line_max_q;
	logic [15:0] size_q;
	logic use_sb_q;
	logic [3:0] idx_q;
	logic unb_q;
	logic signed [31:0] bx_lo_q, bx_hi_q, by_lo_q, by_hi_q, bz_lo_q, bz_hi_q;
	logic [15:0] x_lo_q, x_end_q, y_lo_q, y_end_q;
	logic wr, rd_en, acc, mapped;
	logic [31:0] rdata_d;
	logic [16:0] dclamp;

	// apb: one wait state, pready from a flop
	assign acc = psel && penable && !pready;
	assign wr = psel && penable && pready && pwrite;
	assign rd_en = acc && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= acc;
			pslverr <= acc && !mapped;
			if (rd_en) begin
				prdata <= rdata_d;
			end
		end
	end

	// depth write value clamp
	always_comb begin
		dclamp = pwdata[16:0];
		if (pwdata[31]) begin
			dclamp = DEPTH_ZERO;
		end else if (pwdata[30:0] > {14'h0000, DEPTH_ONE}) begin
			dclamp = DEPTH_ONE;
		end
	end

	always_comb begin
		mapped = 1'b1;
		rdata_d = 32'h00000000;
		case (paddr)
			ADDR_CTRL: rdata_d = {31'h00000000, discard_q};
			ADDR_STATUS: rdata_d = {28'h0000000, status_q};
			ADDR_MASK: rdata_d = {28'h0000000, mask_q};
			ADDR_VP_X: rdata_d = {{16{vp_x_q[15]}}, vp_x_q};
			ADDR_VP_Y: rdata_d = {{16{vp_y_q[15]}}, vp_y_q};
			ADDR_VP_W: rdata_d = {16'h0000, vp_w_q};
			ADDR_VP_H: rdata_d = {16'h0000, vp_h_q};
			ADDR_DEPTH_NEAR: rdata_d = {15'h0000, near_q};
			ADDR_DEPTH_FAR: rdata_d = {15'h0000, far_q};
			ADDR_BB_MIN_XY: rdata_d = {cb_min_q[1], cb_min_q[0]};
			ADDR_BB_MIN_ZW: rdata_d = {cb_min_q[3], cb_min_q[2]};
			ADDR_BB_MAX_XY: rdata_d = {cb_max_q[1], cb_max_q[0]};
			ADDR_BB_MAX_ZW: rdata_d = {cb_max_q[3], cb_max_q[2]};
			ADDR_POINT_MAX: rdata_d = {16'h0000, point_max_q};
			ADDR_LINE_WIDTH: rdata_d = {16'h0000, line_width_q};
			ADDR_LINE_MAX: rdata_d = {16'h0000, line_max_q};
			ADDR_RES_X: rdata_d = {x_end_q, x_lo_q};
			ADDR_RES_Y: rdata_d = {y_end_q, y_lo_q};
			ADDR_RES_ZMIN: rdata_d = bz_lo_q;
			ADDR_RES_ZMAX: rdata_d = bz_hi_q;
			default: mapped = 1'b0;
		endcase
	end

	// control and interrupt registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			discard_q <= 1'b0;
			mask_q <= '0;
			status_q <= '0;
			irq <= 1'b0;
		end else begin
			if (wr && paddr == ADDR_CTRL) begin
				discard_q <= pwdata[CTRL_DISCARD_BIT];
			end
			if (wr && paddr == ADDR_MASK) begin
				mask_q <= pwdata[EVT_W-1:0];
			end
			// set wins over write-one-to-clear
			if (wr && paddr == ADDR_STATUS) begin
				status_q <= (status_q & ~pwdata[EVT_W-1:0]) | evt;
			end else begin
				status_q <= status_q | evt;
			end
			irq <= |(status_q & mask_q);
		end
	end

	// viewport and depth range state
	// four integers, two clamped depths
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_q <= 1'b1;
			vp_x_q <= '0;
			vp_y_q <= '0;
			vp_w_q <= '0;
			vp_h_q <= '0;
			near_q <= DEPTH_ZERO;
			far_q <= DEPTH_ONE;
		end else begin
			init_q <= 1'b0;
			// size from window strap after release
			if (init_q) begin
				vp_w_q <= win_present ? win_width : '0;
				vp_h_q <= win_present ? win_height : '0;
			end else if (wr) begin
				case (paddr)
					ADDR_VP_X: vp_x_q <= pwdata[15:0];
					ADDR_VP_Y: vp_y_q <= pwdata[15:0];
					ADDR_VP_W: if (!pwdata[31]) vp_w_q <= pwdata[15:0];
					ADDR_VP_H: if (!pwdata[31]) vp_h_q <= pwdata[15:0];
					ADDR_DEPTH_NEAR: near_q <= dclamp;
					ADDR_DEPTH_FAR: far_q <= dclamp;
					default: ;
				endcase
			end
		end
	end

	// bounds and size registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				cb_min_q[i] <= BB_MIN_RST;
				cb_max_q[i] <= BB_MAX_RST;
				sb_min_q[i] <= BB_MIN_RST;
				sb_max_q[i] <= BB_MAX_RST;
			end
			point_max_q <= POINT_MAX_RST;
			line_width_q <= LINE_WIDTH_RST;
			line_max_q <= LINE_MAX_RST;
		end else begin
			if (wr) begin
				case (paddr)
					ADDR_BB_MIN_XY: {cb_min_q[1], cb_min_q[0]} <= pwdata;
					ADDR_BB_MIN_ZW: {cb_min_q[3], cb_min_q[2]} <= pwdata;
					ADDR_BB_MAX_XY: {cb_max_q[1], cb_max_q[0]} <= pwdata;
					ADDR_BB_MAX_ZW: {cb_max_q[3], cb_max_q[2]} <= pwdata;
					ADDR_POINT_MAX: point_max_q <= pwdata[15:0];
					ADDR_LINE_WIDTH: line_width_q <= pwdata[15:0];
					ADDR_LINE_MAX: line_max_q <= pwdata[15:0];
					default: ;
				endcase
			end
			// shader_written_bounds element zero min, one max
			if (sb_valid) begin
				sb_min_q[0] <= sb_min_x;
				sb_min_q[1] <= sb_min_y;
				sb_min_q[2] <= sb_min_z;
				sb_min_q[3] <= sb_min_w;
				sb_max_q[0] <= sb_max_x;
				sb_max_q[1] <= sb_max_y;
				sb_max_q[2] <= sb_max_z;
				sb_max_q[3] <= sb_max_w;
			end
		end
	end

	// clear requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_go <= 1'b0;
			per_buffer_clear_go <= 1'b0;
		end else begin
			clear_go <= clear_req && !discard_q;
			per_buffer_clear_go <= per_buffer_clear_req && !discard_q;
		end
	end

	// corner projection, one corner per cycle
	logic [15:0] cc [4];
	logic signed [27:0] ndc [3];
	logic signed [27:0] wden;
	logic signed [47:0] px, py, pz;
	logic signed [31:0] cxw, cyw, czw, ox8, oy8;
	logic signed [17:0] drange;
	logic [15:0] psize, lsize;
	logic accept;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			cc[i] = idx_q[i] ? (use_sb_q ? sb_max_q[i] : cb_max_q[i])
				: (use_sb_q ? sb_min_q[i] : cb_min_q[i]);
		end
		wden = {{12{cc[3][15]}}, cc[3]};
		for (int i = 0; i < 3; i++) begin
			ndc[i] = (wden > 28'sd0) ? ($signed({cc[i], 12'h000}) / wden) : 28'sd0;
		end
		ox8 = {{8{vp_x_q[15]}}, vp_x_q, 8'h00} + {9'h000, vp_w_q, 7'h00};
		oy8 = {{8{vp_y_q[15]}}, vp_y_q, 8'h00} + {9'h000, vp_h_q, 7'h00};
		px = $signed({{20{ndc[0][27]}}, ndc[0]}) * $signed({32'h00000000, vp_w_q});
		py = $signed({{20{ndc[1][27]}}, ndc[1]}) * $signed({32'h00000000, vp_h_q});
		cxw = 32'(px >>> (NDC_FRAC + 1 - WIN_FRAC)) + ox8;
		cyw = 32'(py >>> (NDC_FRAC + 1 - WIN_FRAC)) + oy8;
		// depth from range difference and midpoint
		drange = $signed({1'b0, far_q}) - $signed({1'b0, near_q});
		pz = $signed({{20{ndc[2][27]}}, ndc[2]}) * $signed({{30{drange[17]}}, drange});
		czw = 32'(pz >>> (NDC_FRAC + 1)) + 32'(({1'b0, near_q} + {1'b0, far_q}) >> 1);
	end

	always_comb begin
		psize = (prim_point_size > point_max_q) ? point_max_q : prim_point_size;
		lsize = (line_width_q + SIZE_ROUND) & SIZE_INT_MASK;
		if (lsize > line_max_q) begin
			lsize = line_max_q;
		end
		if (lsize == 16'h0000) begin
			lsize = SIZE_ONE;
		end
	end

	assign accept = prim_valid && prim_ready;

	// expansion of the window volume
	logic signed [31:0] half, ex_lo, ex_hi, ey_lo, ey_hi, fbw, fbh;
	logic signed [31:0] cx_lo, cx_end, cy_lo, cy_end;
	always_comb begin
		half = {17'h00000, size_q[15:1]};
		fbw = {16'h0000, win_width};
		fbh = {16'h0000, win_height};
		// grow by half size, floor min, ceil max
		ex_lo = (bx_lo_q - half) >>> WIN_FRAC;
		ex_hi = (bx_hi_q + half + 32'sd255) >>> WIN_FRAC;
		ey_lo = (by_lo_q - half) >>> WIN_FRAC;
		ey_hi = (by_hi_q + half + 32'sd255) >>> WIN_FRAC;
		cx_lo = (unb_q || ex_lo < 0) ? 32'sd0 : ex_lo;
		cy_lo = (unb_q || ey_lo < 0) ? 32'sd0 : ey_lo;
		cx_end = (unb_q || ex_hi > fbw) ? fbw : ex_hi;
		cy_end = (unb_q || ey_hi > fbh) ? fbh : ey_hi;
	end

	// primitive sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			prim_ready <= 1'b0;
			size_q <= '0;
			use_sb_q <= 1'b0;
			idx_q <= '0;
			unb_q <= 1'b0;
			bx_lo_q <= '0;
			bx_hi_q <= '0;
			by_lo_q <= '0;
			by_hi_q <= '0;
			bz_lo_q <= '0;
			bz_hi_q <= '0;
			x_lo_q <= '0;
			x_end_q <= '0;
			y_lo_q <= '0;
			y_end_q <= '0;
			frag_valid <= 1'b0;
			frag_x <= '0;
			frag_y <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					prim_ready <= !accept;
					if (accept && !discard_q) begin
						// pass to rasterization when enable clear
						state_q <= ST_CORNER;
						// patch bounds follow every derived primitive
						use_sb_q <= prim_use_shader_bounds;
						idx_q <= '0;
						unb_q <= 1'b0;
						case (prim_type)
							PRIM_POINT: size_q <= psize;
							PRIM_LINE: size_q <= lsize;
							default: size_q <= '0;
						endcase
					end
				end
				ST_CORNER: begin
					// any corner with w not above zero makes the volume unbounded (whole framebuffer)
					if (cc[3][15] || cc[3] == 16'h0000) begin
						unb_q <= 1'b1;
					end else if (idx_q == 4'h0 || unb_q) begin
						bx_lo_q <= cxw;
						bx_hi_q <= cxw;
						by_lo_q <= cyw;
						by_hi_q <= cyw;
						bz_lo_q <= czw;
						bz_hi_q <= czw;
					end else begin
						if (cxw < bx_lo_q) bx_lo_q <= cxw;
						if (cxw > bx_hi_q) bx_hi_q <= cxw;
						if (cyw < by_lo_q) by_lo_q <= cyw;
						if (cyw > by_hi_q) by_hi_q <= cyw;
						if (czw < bz_lo_q) bz_lo_q <= czw;
						if (czw > bz_hi_q) bz_hi_q <= czw;
					end
					idx_q <= idx_q + 4'h1;
					if (idx_q == CORNER_LAST) begin
						state_q <= ST_EXPAND;
					end
				end
				ST_EXPAND: begin
					x_lo_q <= cx_lo[15:0];
					y_lo_q <= cy_lo[15:0];
					x_end_q <= cx_end[15:0];
					y_end_q <= cy_end[15:0];
					frag_x <= cx_lo[15:0];
					frag_y <= cy_lo[15:0];
					if (cx_lo >= cx_end || cy_lo >= cy_end) begin
						state_q <= ST_IDLE;
						prim_ready <= 1'b1;
					end else begin
						state_q <= ST_SCAN;
						frag_valid <= 1'b1;
					end
				end
				ST_SCAN: begin
					// every grid square in the volume is offered
					// scan depends only on integer offsets
					if (frag_ready) begin
						if (frag_x + 16'h0001 < x_end_q) begin
							frag_x <= frag_x + 16'h0001;
						end else if (frag_y + 16'h0001 < y_end_q) begin
							frag_x <= x_lo_q;
							frag_y <= frag_y + 16'h0001;
						end else begin
							frag_valid <= 1'b0;
							state_q <= ST_IDLE;
							prim_ready <= 1'b1;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
					prim_ready <= 1'b1;
					frag_valid <= 1'b0;
				end
			endcase
		end
	end

	// event pulses into the sticky status
	always_comb begin
		evt = '0;
		evt[EVT_VP_ERR] = wr && pwdata[31] && (paddr == ADDR_VP_W || paddr == ADDR_VP_H);
		evt[EVT_PRIM_DROP] = accept && discard_q;
		evt[EVT_PRIM_DONE] = (state_q == ST_SCAN && frag_ready && frag_valid
			&& frag_x + 16'h0001 >= x_end_q && frag_y + 16'h0001 >= y_end_q);
		evt[EVT_CLEAR_IGN] = (clear_req || per_buffer_clear_req) && discard_q;
	end
endmodule
`default_nettype wire
